// file: src/eeprom_slave.sv
// Serial memory slave: link-side shifter on sck, array and status on core_clk.
// Assumes the host frames each instruction with cs_n and wp_n is a raw pin.
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
)
(
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Serial link
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so_o,
  output logic      so_oe,
  // Protect pin
  input  wire logic wp_n
);

  // ********************************************************************
  // Link domain state
  // ********************************************************************
  typedef struct packed {
    phase_e      phase;
    logic [2:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  opcode;
    logic [4:0]  addr_bits;
    logic [12:0] addr;
    logic [5:0]  count;
    logic        byte_done;
    logic        busy_seen;
    logic [7:0]  st_seen;
    frame_s      frame;
    logic        frame_tgl;
    logic        wr_tgl;
    logic [12:0] wr_addr;
    logic [7:0]  wr_data;
  } link_s;

  link_s lk_reg;
  link_s lk_next;

  // Page buffer written on sck, read on core_clk after the frame closes
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [7:0]  mem [2**ADDR_W];

  // Core values seen by the link: synced on sck, held across a frame once captured at opcode end
  logic [7:0]  st_link_sync1;
  logic [7:0]  st_link_sync2;

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    op_is = ((op & OP_MASK) == code);
  endfunction

  function automatic logic in_protect(input logic [1:0] bp, input logic [12:0] a);
    case (bp)
      2'b01:   in_protect = (a >= PROT_QUARTER);
      2'b10:   in_protect = (a >= PROT_HALF);
      2'b11:   in_protect = 1'b1;
      default: in_protect = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    logic [7:0] sh;
    sh = {lk_reg.shift[6:0], si};
    lk_next = lk_reg;
    lk_next.bitcnt = lk_reg.bitcnt + 3'h1;
    lk_next.shift = sh;
    lk_next.byte_done = 1'b0;
    case (lk_reg.phase)
      PH_OPCODE:
      begin
        if (lk_reg.bitcnt == 3'h7)
        begin
          lk_next.opcode = sh;
          lk_next.busy_seen = st_link_sync2[ST_BUSY_BIT];
          lk_next.st_seen = st_link_sync2;
          lk_next.phase = PH_IGNORE;
          if (op_is(sh, OP_STATUS_READ))
          begin
            lk_next.phase = PH_STATUS_OUT;
          end
          else if (st_link_sync2[ST_BUSY_BIT])
          begin
            lk_next.phase = PH_IGNORE;
          end
          else if (op_is(sh, OP_READ) || op_is(sh, OP_WRITE))
          begin
            lk_next.phase = PH_ADDR;
            lk_next.addr_bits = 5'h0;
          end
          else if (op_is(sh, OP_STATUS_WRITE))
          begin
            lk_next.phase = PH_STATUS_IN;
          end
          else if (op_is(sh, OP_SET_LATCH))
          begin
            lk_next.frame.latch_set = 1'b1;
          end
          else if (op_is(sh, OP_CLEAR_LATCH))
          begin
            lk_next.frame.latch_clear = 1'b1;
          end
        end
      end
      PH_ADDR:
      begin
        lk_next.addr_bits = lk_reg.addr_bits + 5'h1;
        lk_next.addr = {lk_reg.addr[11:0], si};
        if (lk_reg.addr_bits == 5'hf)
        begin
          if (op_is(lk_reg.opcode, OP_READ))
          begin
            lk_next.phase = PH_RDATA;
          end
          else
          begin
            lk_next.phase = PH_WDATA;
            lk_next.count = 6'h0;
          end
        end
      end
      PH_WDATA:
      begin
        if (lk_reg.bitcnt == 3'h7)
        begin
          lk_next.byte_done = 1'b1;
          lk_next.frame.base = lk_reg.addr;
          lk_next.wr_addr = {lk_reg.addr[12:5], lk_reg.addr[4:0] + lk_reg.count[4:0]};
          lk_next.wr_data = sh;
          lk_next.wr_tgl = ~lk_reg.wr_tgl;
          lk_next.count[4:0] = lk_reg.count[4:0] + 5'h1;
          if (lk_reg.count[4:0] == 5'h1f)
          begin
            lk_next.count[5] = 1'b1;
          end
        end
      end
      PH_RDATA:
      begin
        if (lk_reg.bitcnt == 3'h7)
        begin
          lk_next.addr = lk_reg.addr + 13'h1;
        end
      end
      PH_STATUS_IN:
      begin
        if (lk_reg.bitcnt == 3'h7)
        begin
          lk_next.frame.status_in = sh;
          lk_next.byte_done = 1'b1;
          lk_next.phase = PH_IGNORE;
        end
      end
      default:
      begin
      end
    endcase
  end

  // Frame boundary: cs_n high clears the shifter, rising cs_n posts the job
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      lk_reg.phase <= PH_OPCODE;
      lk_reg.bitcnt <= 3'h0;
      lk_reg.byte_done <= 1'b0;
      lk_reg.frame.latch_set <= 1'b0;
      lk_reg.frame.latch_clear <= 1'b0;
    end
    else
    begin
      lk_reg <= lk_next;
    end
  end

  // Page buffer capture
  always_ff @(posedge sck)
  begin
    if (!cs_n && lk_reg.phase == PH_WDATA && lk_reg.bitcnt == 3'h7)
    begin
      page_buf[lk_reg.addr[4:0] + lk_reg.count[4:0]] <= lk_next.shift;
    end
  end

  // Job decided at cs_n rising; toggled so core sees one event per frame
  logic       post_tgl;
  frame_s     post_frame;
  always_ff @(posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      post_tgl <= 1'b0;
      post_frame <= '0;
    end
    else
    begin
      post_tgl <= ~post_tgl;
      post_frame.job <= JOB_NONE;
      post_frame.base <= lk_reg.frame.base;
      post_frame.count <= lk_reg.count[5] ? 6'(PAGE_BYTES) : lk_reg.count;
      post_frame.status_in <= lk_reg.frame.status_in;
      post_frame.latch_set <= lk_reg.frame.latch_set;
      post_frame.latch_clear <= lk_reg.frame.latch_clear;
      if (lk_reg.byte_done && lk_reg.bitcnt == 3'h0)
      begin
        if (lk_reg.phase == PH_WDATA || op_is(lk_reg.opcode, OP_WRITE))
        begin
          post_frame.job <= JOB_ARRAY;
        end
        else if (op_is(lk_reg.opcode, OP_STATUS_WRITE))
        begin
          post_frame.job <= JOB_STATUS;
        end
      end
    end
  end

  // ********************************************************************
  // Serial output on falling sck
  // ********************************************************************
  logic [7:0] out_byte;
  always_comb
  begin
    out_byte = mem[lk_reg.addr];
    if (lk_reg.phase == PH_STATUS_OUT)
    begin
      out_byte = lk_reg.busy_seen ? ST_BUSY_VALUE : lk_reg.st_seen;
    end
  end

  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= (lk_reg.phase == PH_RDATA || lk_reg.phase == PH_STATUS_OUT);
      so_o <= out_byte[3'h7 - lk_reg.bitcnt];
    end
  end

  // ********************************************************************
  // Core domain state
  // ********************************************************************
  typedef struct packed {
    logic [2:0]  tgl_sync;
    logic        latch;
    logic        pin_en;
    logic [1:0]  bp;
    logic        busy;
    logic [31:0] timer;
    logic [1:0]  wp_sync;
    frame_s      job;
    logic [5:0]  idx;
  } core_s;

  core_s cr_reg;
  core_s cr_next;
  logic  frame_evt;

  assign frame_evt = cr_reg.tgl_sync[2] ^ cr_reg.tgl_sync[1];

  always_comb
  begin
    logic status_ok;
    status_ok = cr_reg.wp_sync[1] || !cr_reg.pin_en;
    cr_next = cr_reg;
    cr_next.tgl_sync = {cr_reg.tgl_sync[1:0], post_tgl};
    cr_next.wp_sync = {cr_reg.wp_sync[0], wp_n};
    if (cr_reg.busy)
    begin
      if (cr_reg.timer == 32'(PROG_COUNT - 1))
      begin
        cr_next.busy = 1'b0;
        if (cr_reg.job.job == JOB_STATUS)
        begin
          cr_next.pin_en = cr_reg.job.status_in[ST_PIN_EN_BIT];
          cr_next.bp = {cr_reg.job.status_in[ST_BP_HI_BIT], cr_reg.job.status_in[ST_BP_LO_BIT]};
        end
      end
      cr_next.timer = cr_reg.timer + 32'h1;
      if (cr_reg.idx != 6'h0)
      begin
        cr_next.idx = cr_reg.idx - 6'h1;
      end
    end
    else if (frame_evt)
    begin
      cr_next.job = post_frame;
      cr_next.idx = post_frame.count;
      cr_next.timer = 32'h0;
      if (post_frame.latch_set)
      begin
        cr_next.latch = 1'b1;
      end
      if (post_frame.latch_clear)
      begin
        cr_next.latch = 1'b0;
      end
      if (cr_reg.latch && (post_frame.job == JOB_ARRAY ||
          (post_frame.job == JOB_STATUS && status_ok)))
      begin
        cr_next.busy = 1'b1;
        cr_next.latch = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cr_reg <= '0;
    end
    else
    begin
      cr_reg <= cr_next;
    end
  end

  // Array programming: one buffered byte per core cycle while busy
  logic [12:0] prog_addr;
  assign prog_addr = {cr_reg.job.base[12:5], cr_reg.job.base[4:0] + 5'(cr_reg.idx - 6'h1)};
  always_ff @(posedge core_clk)
  begin
    if (cr_reg.busy && cr_reg.job.job == JOB_ARRAY && cr_reg.idx != 6'h0
        && !in_protect(cr_reg.bp, prog_addr))
    begin
      mem[prog_addr] <= page_buf[prog_addr[4:0]];
    end
  end

  // Status byte passed to the link; only sampled at opcode end
  always_ff @(posedge sck)
  begin
    st_link_sync1 <= {cr_reg.pin_en, 3'h0, cr_reg.bp, cr_reg.latch, cr_reg.busy};
    st_link_sync2 <= st_link_sync1;
  end

endmodule

// file: src/eeprom_pkg.sv
// Package for the serial nonvolatile memory slave.
// Assumes one core clock at 50 MHz and one serial link clock from the host.
package eeprom_pkg;

  // ********************************************************************
  // Array geometry and timing
  // ********************************************************************
  localparam int          ADDR_W          = 13;
  localparam int          PAGE_BYTES      = 32;
  localparam int          PAGE_W          = 5;
  localparam int          CORE_CLK_MHZ    = 50;
  localparam int          PROG_TIME_US    = 5000;
  localparam int          PROG_CYCLES     = PROG_TIME_US * CORE_CLK_MHZ;

  // ********************************************************************
  // Status register fields
  // ********************************************************************
  localparam int          ST_PIN_EN_BIT   = 7;
  localparam int          ST_BP_HI_BIT    = 3;
  localparam int          ST_BP_LO_BIT    = 2;
  localparam int          ST_LATCH_BIT    = 1;
  localparam int          ST_BUSY_BIT     = 0;
  localparam logic [7:0]  ST_BUSY_VALUE   = 8'hff;

  // ********************************************************************
  // Protect region starts
  // ********************************************************************
  localparam logic [12:0] PROT_QUARTER    = 13'h1800;
  localparam logic [12:0] PROT_HALF       = 13'h1000;

  // ********************************************************************
  // Opcodes, bit 3 masked
  // ********************************************************************
  localparam logic [7:0]  OP_MASK         = 8'hf7;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_WRITE        = 8'h02;
  localparam logic [7:0]  OP_SET_LATCH    = 8'h06;
  localparam logic [7:0]  OP_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
  localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_STATUS_OUT,
    PH_STATUS_IN,
    PH_IGNORE
  } phase_e;

  typedef enum logic [1:0] {
    JOB_NONE,
    JOB_ARRAY,
    JOB_STATUS
  } job_e;

  // Frame result handed from link domain to core domain
  typedef struct packed {
    job_e        job;
    logic [12:0] base;
    logic [5:0]  count;
    logic [7:0]  status_in;
    logic        latch_set;
    logic        latch_clear;
  } frame_s;

endpackage

// file: dv/eeprom_slave_monitor.sv
// Checker of the slave's serial output timing and drive windows.
// Assumes binding to eeprom_slave; sees its ports only.
module eeprom_slave_monitor
  import eeprom_pkg::*;
(
  // Clocks and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic sck,
  // Serial link
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic so_o,
  input  wire logic so_oe,
  // Protect pin
  input  wire logic wp_n
);
  // ******************************************************************
  // Frame bit counter and opcode capture
  // ******************************************************************
  logic [5:0] bit_cnt;
  logic [7:0] op_reg;
  logic [7:0] op_m;
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt <= 6'h00;
      op_reg  <= 8'h00;
    end
    else
    begin
      if (bit_cnt < 6'h20) bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt < 6'h08) op_reg <= {op_reg[6:0], si};
    end
  end
  assign op_m = op_reg & OP_MASK;

  chk_oe_deselect: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_n |-> !so_oe) else $error("output driven while deselected");
  chk_so_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    (so_oe && $past(so_oe) && so_o != $past(so_o)) |-> !sck)
    else $error("output changed while sck high");
  chk_opcode_quiet: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    bit_cnt < 6'h08 |-> !so_oe) else $error("output driven during opcode");
  chk_status_drive: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    (op_m == OP_STATUS_READ && bit_cnt >= 6'h08 && bit_cnt < 6'h10) |-> so_oe)
    else $error("status byte not driven");
  chk_read_addr_quiet: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    (op_m == OP_READ && bit_cnt >= 6'h08 && bit_cnt < 6'h18) |-> !so_oe)
    else $error("output driven during address");
  chk_read_drive: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    (op_m == OP_READ && bit_cnt >= 6'h18) |-> so_oe) else $error("read data not driven");
  chk_write_quiet: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    ((op_m == OP_WRITE || op_m == OP_STATUS_WRITE) && bit_cnt >= 6'h08) |-> !so_oe)
    else $error("output driven during write");
  chk_latch_quiet: assert property (@(posedge sck) disable iff (cs_n || !rst_n)
    ((op_m == OP_SET_LATCH || op_m == OP_CLEAR_LATCH) && bit_cnt >= 6'h08) |-> !so_oe)
    else $error("output driven after latch command");
endmodule

bind eeprom_slave eeprom_slave_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
  .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n));

// file: dv/spi_host_model.sv
// Host controller model: frames instructions with cs_n, clocks sck, msb first.
// Assumes the slave drives so_o after falling sck; sck idles low.
module spi_host_model
(
  // Serial link
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 24ns;
  initial
  begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  // Few edges with select high so the slave's status sync settles
  task automatic warm();
    repeat (4)
    begin
      #HALF sck = ~sck;
    end
  endtask
  // Whole bytes only, select raised at the byte boundary
  task automatic frame(input logic [7:0] tx[$], input int n_rx, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    #HALF cs_n = 1'b0;
    for (int i = 0; i < tx.size() + n_rx; i++)
    begin
      for (int k = 7; k >= 0; k--)
      begin
        si = (i < tx.size()) ? tx[i][k] : k[0];
        #HALF sck = 1'b1;
        b[k] = so_o;
        #HALF sck = 1'b0;
      end
      rx.push_back(b);
    end
    #HALF cs_n = 1'b1;
    si = ~si;
    #(8 * HALF);
  endtask
endmodule

// file: dv/test_spi_eeprom_protect_rw_engine.sv
// Self-checking bench of the serial memory slave.
// Assumes spi_host_model drives the link and the monitor is bound.
module test_spi_eeprom_protect_rw_engine
  import eeprom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk;
  logic       rst_n;
  logic       wp_n;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       so_o;
  logic       so_oe;
  int         mismatches;
  int         checks_done;
  int         cycles;
  logic [7:0] s;
  logic [7:0] q[$];
  logic [7:0] d[$];

  eeprom_slave #(.PROG_COUNT(200)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
    .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n));
  spi_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o));

  always #10 core_clk = ~core_clk;
  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx[$];
    host_u.frame('{op}, 0, rx);
  endtask
  task automatic status(output logic [7:0] v);
    logic [7:0] rx[$];
    host_u.frame('{OP_STATUS_READ}, 1, rx);
    v = rx[1];
  endtask
  task automatic wait_ready();
    logic [7:0] v;
    v = 8'hff;
    for (int i = 0; i < 40 && v[0] !== 1'b0; i++) status(v);
    check("ready", {7'h00, v[0]}, 8'h00);
  endtask
  task automatic wr_raw(input logic [15:0] a, input logic [7:0] data[$]);
    logic [7:0] rx[$];
    logic [7:0] tx[$];
    tx = data;
    tx.push_front(a[7:0]);
    tx.push_front(a[15:8]);
    tx.push_front(OP_WRITE);
    host_u.frame(tx, 0, rx);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] data[$]);
    cmd(OP_SET_LATCH);
    wr_raw(a, data);
    wait_ready();
  endtask
  task automatic st_wr(input logic [7:0] v);
    logic [7:0] rx[$];
    cmd(OP_SET_LATCH);
    host_u.frame('{OP_STATUS_WRITE, v}, 0, rx);
    wait_ready();
  endtask
  task automatic rd(input logic [15:0] a, input int n, output logic [7:0] r[$]);
    logic [7:0] rx[$];
    host_u.frame('{OP_READ, a[15:8], a[7:0]}, n, rx);
    r = rx[3:$];
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_latch();
    status(s);
    check("status_reset", s, 8'h00);
    cmd(OP_SET_LATCH);
    status(s);
    check("latch_set", s, 8'h02);
    cmd(OP_CLEAR_LATCH | 8'h08);
    status(s);
    check("latch_clear", s, 8'h00);
  endtask
  task automatic t_write();
    cmd(OP_SET_LATCH | 8'h08);
    wr_raw(16'h0010, '{8'h11, 8'h22, 8'h33, 8'h44});
    status(s);
    check("busy_status", s, ST_BUSY_VALUE);
    cmd(OP_SET_LATCH);
    wait_ready();
    status(s);
    check("latch_after_write", s, 8'h00);
    rd(16'h0010, 4, q);
    foreach (q[i]) check("read_seq", q[i], 8'(8'h11 * (i + 1)));
    wr_raw(16'h0010, '{8'h99});
    status(s);
    check("discard_status", s, 8'h00);
    rd(16'h0010, 1, q);
    check("discard_data", q[0], 8'h11);
  endtask
  task automatic t_page_wrap();
    d = {};
    for (int i = 0; i < 34; i++) d.push_back(8'(8'h40 + i));
    wr(16'h0040, d);
    rd(16'h0040, 2, q);
    check("page_wrap0", q[0], 8'h60);
    check("page_wrap1", q[1], 8'h61);
    wr(16'h0000, '{8'h5a});
    wr(16'hffff, '{8'ha5});
    rd(16'h1fff, 2, q);
    check("top_byte", q[0], 8'ha5);
    check("read_wrap", q[1], 8'h5a);
  endtask
  task automatic t_protect();
    wr(16'h1800, '{8'h18});
    st_wr(8'h04);
    status(s);
    check("bp_status", s, 8'h04);
    wr(16'h1800, '{8'h81});
    wr(16'h17ff, '{8'h71});
    rd(16'h17ff, 2, q);
    check("open_byte", q[0], 8'h71);
    check("guarded_byte", q[1], 8'h18);
    st_wr(8'h84);
    status(s);
    check("pin_en_set", s, 8'h84);
    @(negedge core_clk) wp_n = 1'b0;
    st_wr(8'h00);
    status(s);
    check("pin_refuse", s, 8'h86);
    wr(16'h17ff, '{8'h72});
    rd(16'h17ff, 1, q);
    check("pin_open_byte", q[0], 8'h72);
    @(negedge core_clk) wp_n = 1'b1;
    st_wr(8'h00);
    status(s);
    check("pin_high_write", s, 8'h00);
  endtask
  task automatic t_block_sizes();
    st_wr(8'h08);
    wr(16'h17ff, '{8'h73});
    wr(16'h0fff, '{8'h0f});
    rd(16'h17ff, 1, q);
    check("half_guard", q[0], 8'h72);
    rd(16'h0fff, 1, q);
    check("half_open", q[0], 8'h0f);
    st_wr(8'h0c);
    status(s);
    check("bp_all_status", s, 8'h0c);
    wr(16'h0000, '{8'hee});
    rd(16'h0000, 1, q);
    check("all_guard", q[0], 8'h5a);
    st_wr(8'h00);
    status(s);
    check("bp_none_status", s, 8'h00);
  endtask
  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    core_clk    = 1'b0;
    rst_n       = 1'b0;
    wp_n        = 1'b1;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    host_u.warm();
    t_latch();
    t_write();
    t_page_wrap();
    t_protect();
    t_block_sizes();
    complete_run();
  end
endmodule
